// ---- hw/spi_router_pkg.sv ----
// Constants, field layout and state codes for the select router
package spi_router_pkg;

	localparam int CLK_PERIOD_NS     = 10;
	localparam int SAMPLE_NS         = 1200;
	localparam int SAMPLE_CYCLES     = SAMPLE_NS / CLK_PERIOD_NS;
	localparam int GLITCH_NS         = 20;
	localparam int GLITCH_CYCLES     = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEL_FILTER_NS     = 10;
	localparam int SEL_FILTER_CYCLES = (SEL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WATCHDOG_NS       = 5000;
	localparam int WATCHDOG_CYCLES   = WATCHDOG_NS / CLK_PERIOD_NS;

	localparam int SAMPLE_W = 8;
	localparam int WD_W     = 10;
	localparam int FILT_W   = 2;

	localparam logic [SAMPLE_W-1:0] SAMPLE_LAST = SAMPLE_W'(SAMPLE_CYCLES - 1);
	localparam logic [WD_W-1:0]     WD_LAST     = WD_W'(WATCHDOG_CYCLES - 1);

	// Packet: start bit on top, then address, select and fast levels
	localparam int PKT_W    = 6;
	localparam int PKT_CLK  = 0;
	localparam int PKT_MO   = 1;
	localparam int PKT_SEL  = 2;
	localparam int PKT_A0   = 3;
	localparam int PKT_A1   = 4;

	// Synchroniser channel indices
	localparam int CH_CLK  = 0;
	localparam int CH_MO   = 1;
	localparam int CH_MISO = 2;
	localparam int CH_SEL  = 3;
	localparam int CH_A0   = 4;
	localparam int CH_A1   = 5;
	localparam int CH_PW1  = 6;
	localparam int CH_PW2  = 7;
	localparam int NUM_CH  = 8;

	localparam logic [11:0] CTRL_ADDR   = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam int          CTRL_NOISE_BIT = 0;
	localparam logic        CTRL_NOISE_RESET = 1'b1;
	localparam int          ST_PW1   = 0;
	localparam int          ST_PW2   = 1;
	localparam int          ST_VALID = 2;
	localparam int          ST_ROUTE = 3;
	localparam int          ST_DEAD  = 5;

	typedef enum logic [2:0] {
		LINK_DOWN = 3'b001,
		LINK_WAIT = 3'b010,
		LINK_UP   = 3'b100
	} link_state_t;

endpackage : spi_router_pkg

// ---- hw/spi_target_select_router.sv ----
// Serial bus pass-through with sampled target-select router and APB control
//
// Functional notes
// [R1] Either side unpowered: returned, far outputs float
// [R2] Clock, data copied across keeping levels
// [R3] Four fast channels: clock, out, return, select
// [R4] Noise variant filters clock and data channels
// [R5] Missed edge corrected by next edge or refresh
// [R6] No sync to serial clock; any mode
// [R7] Returned data always driven while powered
// [R8] Target select is active low
// [R9] Select path always glitch filtered
// [R10] Controller sets select up before clock edge
// [R11] Select goes to exactly one of four
// [R12] Address hi,lo picks target output 0..3
// [R13] Inputs sampled together, packed, shifted across
// [R14] Far side checks levels, passes address
// [R15] Address sampled by free-running clock, bounded delay
// [R16] Unaddressed select outputs float
// [R17] Controller changes both address bits together
// [R18] Route changes after two equal address samples
// [R19] Route switches cleanly, no intermediate state
// [R20] Periodic refresh carries levels when idle
// [R21] Watchdog floats outputs when packets stop
// [R22] Selects float until two consistent samples
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module spi_target_select_router
	import spi_router_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        side1_powered,
	input  wire logic        side2_powered,
	input  wire logic        main_serial_clock,
	input  wire logic        main_data_out,
	input  wire logic        main_target_sel_n,
	input  wire logic        addr_lo_bit,
	input  wire logic        addr_hi_bit,
	input  wire logic        far_data_from_target,
	output logic             main_data_return,
	output logic             main_data_return_oe,
	output logic             far_serial_clock,
	output logic             far_serial_clock_oe,
	output logic             far_data_to_target,
	output logic             far_data_to_target_oe,
	output logic             target_sel_0,
	output logic             target_sel_0_oe,
	output logic             target_sel_1,
	output logic             target_sel_1_oe,
	output logic             target_sel_2,
	output logic             target_sel_2_oe,
	output logic             target_sel_3,
	output logic             target_sel_3_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and filters

	logic [NUM_CH-1:0] pin_vec;
	logic [NUM_CH-1:0] ch_s;
	logic [NUM_CH-1:0] ch_f;
	logic [NUM_CH-1:0] filt_en;
	logic              noise_mode;

	assign pin_vec = {side2_powered, side1_powered, addr_hi_bit, addr_lo_bit,
		main_target_sel_n, far_data_from_target, main_data_out, main_serial_clock};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			localparam int FC = (gi == CH_SEL) ? SEL_FILTER_CYCLES : GLITCH_CYCLES;
			// Select always filtered; clock and data only in noise mode
			assign filt_en[gi] = (gi == CH_SEL) ? 1'b1 :       // R9
				(gi <= CH_MISO) ? noise_mode : 1'b0;           // R4
			sync_filter #(.FILTER_CYCLES(FC)) u_sync (
				.clk        (clk),
				.reset_n    (reset_n),
				.pin        (pin_vec[gi]),
				.filter_en  (filt_en[gi]),
				.level_sync (ch_s[gi]),
				.level_out  (ch_f[gi])
			);
		end
	endgenerate

	logic both_pw;
	assign both_pw = ch_f[CH_PW1] & ch_f[CH_PW2];

	////////////////////////////////////////////////////////////////////////////////
	// Main side: free-running sample clock and packet serialiser

	logic [SAMPLE_W-1:0] samp_cnt;
	logic [PKT_W-1:0]    tx_shift;
	logic                tick;
	logic                barrier_line;
	logic [PKT_W-1:0]    tx_word;

	assign tick         = (samp_cnt == SAMPLE_LAST);           // R15
	assign barrier_line = tx_shift[PKT_W-1];
	// All levels captured in the same cycle
	assign tx_word = {1'b1, ch_f[CH_A1], ch_f[CH_A0], ch_f[CH_SEL],
		ch_f[CH_MO], ch_f[CH_CLK]};                            // R13

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			samp_cnt <= '0;
		end else begin
			samp_cnt <= tick ? '0 : samp_cnt + 1'b1;
		end
	end

	// Refresh packet every sample period while side 1 is powered
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_shift <= '0;
		end else if (tick && ch_f[CH_PW1]) begin
			tx_shift <= tx_word;                               // R20
		end else begin
			tx_shift <= {tx_shift[PKT_W-2:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Far side: deserialiser, watchdog and route control

	logic [PKT_W-1:0] rx_shift;
	logic             pkt_strobe;
	logic [1:0]       pkt_addr;
	logic [1:0]       addr_prev;
	logic [1:0]       route;
	logic [WD_W-1:0]  wd_cnt;
	logic             wd_expire;
	logic             addr_agree;
	link_state_t      link;
	link_state_t      next_link;
	logic             route_valid;
	logic             dead;

	assign pkt_strobe  = rx_shift[PKT_W-1];
	assign pkt_addr    = {rx_shift[PKT_A1], rx_shift[PKT_A0]};  // R12
	assign addr_agree  = pkt_strobe && (pkt_addr == addr_prev);
	assign wd_expire   = (wd_cnt == WD_LAST);
	assign route_valid = (link == LINK_UP);
	assign dead        = (link == LINK_DOWN);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_shift <= '0;
		end else if (!ch_f[CH_PW2]) begin
			rx_shift <= '0;
		end else if (pkt_strobe) begin
			rx_shift <= {{(PKT_W-1){1'b0}}, barrier_line};
		end else begin
			rx_shift <= {rx_shift[PKT_W-2:0], barrier_line};   // R13
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wd_cnt <= '0;
		end else if (pkt_strobe) begin
			wd_cnt <= '0;
		end else if (!wd_expire) begin
			wd_cnt <= wd_cnt + 1'b1;                           // R21
		end
	end

	always_comb begin
		next_link = link;
		case (link)
			LINK_DOWN: begin
				if (pkt_strobe) begin
					next_link = LINK_WAIT;
				end
			end
			LINK_WAIT: begin
				if (addr_agree) begin
					next_link = LINK_UP;                       // R22
				end else if (wd_expire) begin
					next_link = LINK_DOWN;
				end
			end
			LINK_UP: begin
				if (wd_expire) begin
					next_link = LINK_DOWN;                     // R21
				end
			end
			default: begin
				next_link = LINK_DOWN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link <= LINK_DOWN;
		end else begin
			link <= next_link;
		end
	end

	// Route moves only when two consecutive samples agree
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_prev <= 2'h0;
			route     <= 2'h0;
		end else if (pkt_strobe) begin
			addr_prev <= pkt_addr;                             // R14
			if (addr_agree) begin
				route <= pkt_addr;                             // R18
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fast paths: edge driven, corrected by refresh packets

	logic [1:0] fast_q;
	logic [1:0] seen;
	logic [1:0] quiet;

	generate
		for (gi = 0; gi < 2; gi++) begin : g_fast
			logic edge_seen;
			assign edge_seen = ch_f[gi] != seen[gi];          // R6
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					seen[gi]   <= 1'b0;
					quiet[gi]  <= 1'b0;
					fast_q[gi] <= 1'b0;
				end else begin
					seen[gi]  <= ch_f[gi];
					quiet[gi] <= tick | (quiet[gi] & ~edge_seen);
					if (edge_seen) begin
						fast_q[gi] <= ch_f[gi];                // R2
					end else if (pkt_strobe && quiet[gi]) begin
						fast_q[gi] <= rx_shift[gi];            // R5
					end
				end
			end
		end
	endgenerate

	logic [3:0] next_sel_oe;
	logic [3:0] sel_oe;
	logic       sel_lvl;
	logic       far_en;

	assign far_en = both_pw & ~dead;

	generate
		for (gi = 0; gi < 4; gi++) begin : g_route
			// Only the addressed output drives; the rest float
			assign next_sel_oe[gi] = far_en & route_valid
				& (route == 2'(gi));                           // R11 R16 R22
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			main_data_return      <= 1'b0;
			main_data_return_oe   <= 1'b0;
			far_serial_clock      <= 1'b0;
			far_serial_clock_oe   <= 1'b0;
			far_data_to_target    <= 1'b0;
			far_data_to_target_oe <= 1'b0;
			sel_lvl               <= 1'b1;
			sel_oe                <= 4'h0;
		end else begin
			main_data_return      <= ch_f[CH_MISO];           // R2 R3
			main_data_return_oe   <= both_pw;                 // R1 R7
			far_serial_clock      <= fast_q[CH_CLK];          // R3
			far_serial_clock_oe   <= far_en;                  // R1
			far_data_to_target    <= fast_q[CH_MO];
			far_data_to_target_oe <= far_en;
			sel_lvl               <= ch_f[CH_SEL];            // R8
			sel_oe                <= next_sel_oe;             // R19
		end
	end

	assign target_sel_0    = sel_lvl;
	assign target_sel_1    = sel_lvl;
	assign target_sel_2    = sel_lvl;
	assign target_sel_3    = sel_lvl;
	assign target_sel_0_oe = sel_oe[0];
	assign target_sel_1_oe = sel_oe[1];
	assign target_sel_2_oe = sel_oe[2];
	assign target_sel_3_oe = sel_oe[3];

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state per access

	logic        sel_ctrl;
	logic        sel_status;
	logic        mapped;
	logic        access;
	logic        wr_ctrl;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	assign sel_ctrl    = (paddr == CTRL_ADDR);
	assign sel_status  = (paddr == STATUS_ADDR);
	assign mapped      = sel_ctrl | sel_status;
	assign access      = psel & penable & ~pready;
	assign wr_ctrl     = psel & penable & pready & pwrite & sel_ctrl;
	assign status_word = {26'h0, dead, route, route_valid, ch_f[CH_PW2], ch_f[CH_PW1]};

	always_comb begin
		rd_word = 32'h0;
		if (sel_ctrl) begin
			rd_word[CTRL_NOISE_BIT] = noise_mode;
		end else if (sel_status) begin
			rd_word = status_word;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= access;
			pslverr <= access & ~mapped;
			prdata  <= (access & ~pwrite) ? rd_word : 32'h0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			noise_mode <= CTRL_NOISE_RESET;
		end else if (wr_ctrl) begin
			noise_mode <= pwdata[CTRL_NOISE_BIT];             // R4
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_return_driven: assert property (both_pw |=> main_data_return_oe) // R7
		else $error("returned data not driven while powered");

	a_unpowered_float: assert property (!both_pw |=> !far_serial_clock_oe // R1
		&& !far_data_to_target_oe && !main_data_return_oe && sel_oe == 4'h0)
		else $error("output driven with a side unpowered");

	a_one_target: assert property ($onehot0(sel_oe)) // R11
		else $error("more than one target select driven");

	a_route_two_samples: assert property ($changed(route) // R18
		|-> $past(pkt_strobe) && $past(pkt_addr) == $past(addr_prev))
		else $error("route changed without two equal samples");

	a_boot_float: assert property (!route_valid |=> sel_oe == 4'h0) // R22
		else $error("target select driven before route valid");

	a_data_copy: assert property (1'b1 |=> fast_q[CH_MO] == $past(ch_f[CH_MO])) // R2
		else $error("far data does not follow main data");

	a_watchdog_trip: assert property (!pkt_strobe && wd_expire |=> dead) // R21
		else $error("watchdog did not float outputs");

	a_packet_arrives: assert property (tick && both_pw ##1 both_pw [*7] // R13
		|-> ##[1:8] $past(pkt_strobe))
		else $error("sample packet did not cross");

	a_select_glitch: assert property ($changed(ch_s[CH_SEL]) ##1 $changed(ch_s[CH_SEL]) // R9
		&& ch_s[CH_SEL] == ch_f[CH_SEL] |-> $stable(ch_f[CH_SEL]) [*2])
		else $error("select glitch reached output");

	a_route_addressed: assert property (sel_oe != 4'h0 // R12
		|-> sel_oe[$past(route)] && $past(route_valid))
		else $error("driven select is not the addressed one");

	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("APB access not answered");

endmodule : spi_target_select_router

// ---- hw/sync_filter.sv ----
// Two-flop synchroniser followed by an optional glitch filter
`timescale 1ns/1ps
module sync_filter
	import spi_router_pkg::*;
#(
	parameter int FILTER_CYCLES = 1
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic pin,
	input  wire logic filter_en,
	output logic      level_sync,
	output logic      level_out
);

	localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILTER_CYCLES);

	logic              meta;
	logic [FILT_W-1:0] cnt;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta       <= 1'b0;
			level_sync <= 1'b0;
		end else begin
			meta       <= pin;
			level_sync <= meta;
		end
	end

	// New level must hold for FILTER_CYCLES+1 edges before it passes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt       <= '0;
			level_out <= 1'b0;
		end else if (!filter_en || level_sync == level_out) begin
			cnt       <= '0;
			level_out <= level_sync;
		end else if (cnt == FILT_LAST) begin
			cnt       <= '0;
			level_out <= level_sync;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

endmodule : sync_filter

// ---- tb/spi_far_model.sv ----
// Far-side targets: pulled-up select lines and a registered data echo
`timescale 1ns/1ps
module spi_far_model (
	input  wire logic       clk,
	input  wire logic [3:0] sel_val,
	input  wire logic [3:0] sel_oe,
	input  wire logic       data_in,
	input  wire logic       data_in_oe,
	output logic      [3:0] sel_line,
	output logic            data_back
);
	// Released select lines rest at the pull-up level
	assign sel_line = (sel_val & sel_oe) | ~sel_oe;
	// A selected target echoes inverted data; deselected, the plain level shows
	always_ff @(posedge clk) begin
		data_back <= (~&sel_line && data_in_oe) ? ~data_in : data_in;
	end
endmodule : spi_far_model

// ---- tb/testbench.sv ----
// Self-checking bench for the serial select router
`timescale 1ns/1ps
module testbench
	import spi_router_pkg::*;
();
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, seen;
	logic        side1_powered = 1'b1, side2_powered = 1'b1, frame_on = 1'b0;
	logic        main_serial_clock = 1'b0, main_data_out = 1'b0, main_target_sel_n = 1'b1;
	logic        addr_lo_bit = 1'b0, addr_hi_bit = 1'b0;
	logic        far_data_from_target, main_data_return, main_data_return_oe;
	logic        far_serial_clock, far_serial_clock_oe, far_data_to_target, far_data_to_target_oe;
	wire  [3:0]  sel_val, sel_oe, sel_line;
	int          miscompares = 0, total_checks = 0, n, mc, fc, k;

	spi_target_select_router dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .side1_powered(side1_powered), .side2_powered(side2_powered),
		.main_serial_clock(main_serial_clock), .main_data_out(main_data_out),
		.main_target_sel_n(main_target_sel_n), .addr_lo_bit(addr_lo_bit),
		.addr_hi_bit(addr_hi_bit), .far_data_from_target(far_data_from_target),
		.main_data_return(main_data_return), .main_data_return_oe(main_data_return_oe),
		.far_serial_clock(far_serial_clock), .far_serial_clock_oe(far_serial_clock_oe),
		.far_data_to_target(far_data_to_target), .far_data_to_target_oe(far_data_to_target_oe),
		.target_sel_0(sel_val[0]), .target_sel_0_oe(sel_oe[0]),
		.target_sel_1(sel_val[1]), .target_sel_1_oe(sel_oe[1]),
		.target_sel_2(sel_val[2]), .target_sel_2_oe(sel_oe[2]),
		.target_sel_3(sel_val[3]), .target_sel_3_oe(sel_oe[3]));

	spi_far_model far (.clk(clk), .sel_val(sel_val), .sel_oe(sel_oe),
		.data_in(far_data_to_target), .data_in_oe(far_data_to_target_oe),
		.sel_line(sel_line), .data_back(far_data_from_target));

	always #5 clk = ~clk;
	// Serial clock runs only within frames, phase unrelated to clk
	initial begin
		#3;
		forever #80 if (frame_on) main_serial_clock = ~main_serial_clock;
	end
	always @(main_serial_clock) mc++;
	always @(far_serial_clock) fc++;

	////////////////////////////////////////////////////////////////
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask : tick

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int w;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		w = 0;
		do begin
			tick(1);
			w++;
		end while (pready !== 1'b1 && w < 20);
		rd = prdata;
		err = pslverr;
		if (w >= 20) begin
			check(0, 1, "apb timeout");
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask : apb

	task automatic wait_route(input int t);
		n = 0;
		while (sel_oe !== 4'(1 << t) && n < 400) begin
			tick(1);
			n++;
			check(32'($onehot0(sel_oe)), 1, "route switch");
		end
		if (n >= 400) begin
			check(0, 1, "route timeout");
			wrap_up();
		end
		check(32'(n >= SAMPLE_CYCLES && n <= 260), 1, "route delay");
	endtask : wait_route

	////////////////////////////////////////////////////////////////
	initial begin
		tick(5);
		reset_n <= 1'b1;
		tick(1);
		check(sel_oe, 4'h0, "selects before route");
		apb(1'b0, CTRL_ADDR, 32'h0);
		check(rd, 32'h1, "ctrl reset");
		check(err, 1'b0, "ctrl no error");
		apb(1'b0, STATUS_ADDR, 32'h0);
		check(rd, 32'h23, "power status");
		apb(1'b0, 12'h008, 32'h0);
		check(rd, 32'h0, "unmapped data");
		check(err, 1'b1, "unmapped error");
		for (int i = 0; i < 4; i++) begin
			k = (i * 3) % 4;
			if (i == 2) begin
				apb(1'b1, CTRL_ADDR, 32'h0);
				apb(1'b0, CTRL_ADDR, 32'h0);
				check(rd, 32'h0, "ctrl write");
			end
			{addr_hi_bit, addr_lo_bit} <= 2'(k);
			wait_route(k);
			main_target_sel_n <= 1'b0;
			tick(10);
			check(sel_line, 4'hF ^ (4'h1 << k), "select low");
			main_target_sel_n <= 1'b1;
			tick(1);
			main_target_sel_n <= 1'b0;
			seen = 1'b0;
			repeat (10) begin
				tick(1);
				if (sel_line[k] !== 1'b0) seen = 1'b1;
			end
			check(seen, 1'b0, "select pulse");
			main_data_out <= ~main_data_out;
			tick(16);
			check(far_data_to_target, main_data_out, "data out");
			check({main_data_return_oe, main_data_return}, {1'b1, ~main_data_out}, "return");
			main_data_out <= ~main_data_out;
			tick(2);
			main_data_out <= ~main_data_out;
			seen = 1'b0;
			repeat (12) begin
				tick(1);
				if (far_data_to_target !== main_data_out) seen = 1'b1;
			end
			check(seen, i >= 2, "short pulse");
			mc = 0;
			fc = 0;
			frame_on <= 1'b1;
			tick(16 * (i + 4));
			frame_on <= 1'b0;
			tick(20);
			check(fc, mc, "clock edges");
			check(far_serial_clock, main_serial_clock, "clock level");
			main_target_sel_n <= 1'b1;
			tick(10);
			check(sel_line, 4'hF, "select idle");
			check(main_data_return_oe, 1'b1, "return driven");
			tick(400);
		end
		side2_powered <= 1'b0;
		tick(12);
		check({main_data_return_oe, far_serial_clock_oe, far_data_to_target_oe, sel_oe},
			0, "pwr2");
		side2_powered <= 1'b1;
		side1_powered <= 1'b0;
		tick(12);
		check(main_data_return_oe, 1'b0, "pwr1");
		tick(600);
		check({sel_oe, far_serial_clock_oe}, 5'h0, "watchdog");
		apb(1'b0, STATUS_ADDR, 32'h0);
		check(rd, 32'h2A, "watchdog status");
		side1_powered <= 1'b1;
		wait_route(k);
		apb(1'b0, STATUS_ADDR, 32'h0);
		check(rd, 32'h0F, "routed status");
		wrap_up();
	end
endmodule : testbench
